// >>> include/phy_dq_pkg.sv
package phy_dq_pkg;

  // Pin lanes and strobe groups at the widest mode.
  localparam int DQ_LANES = 36;
  localparam int STROBE_GROUPS = 4;
  localparam int DDR_GROUP_BITS = 8;
  localparam int QDR_GROUP_BITS = 9;

  // Memory clock timing derived from the system clock.
  localparam int CLK_FREQ_MHZ = 10;
  localparam int HALF_PERIOD_CYC = 4;
  localparam int READ_LATENCY = 2;

  // Calibration is repeated after this interval.
  localparam int CAL_INTERVAL_US = 1000;
  localparam int CAL_INTERVAL_CYC = CAL_INTERVAL_US * CLK_FREQ_MHZ;

  // Capture phase held until the first calibration completes; no read is sampled with it.
  localparam int CAP_PHASE_RST = 2;

  localparam logic MEM_DDR = 1'b0;
  localparam logic MEM_QDR = 1'b1;

  typedef enum logic [2:0] {
    BUS_X8 = 3'h0,
    BUS_X9 = 3'h1,
    BUS_X16 = 3'h2,
    BUS_X18 = 3'h3,
    BUS_X32 = 3'h4,
    BUS_X36 = 3'h5
  } bus_mode_type;

  typedef enum logic [2:0] {
    OP_IDLE = 3'h1,
    OP_WRITE = 3'h2,
    OP_READ = 3'h4
  } op_type;

endpackage

// >>> src/memory_phy_dq_grouping.sv
// How it works
// - For DDR and DDR2 memory the strobe is driven only while writing and is never used to capture reads.
// - Read data is sampled at a capture phase made inside the block from its own clock.
// - Captured read data never passes through a strobe clock domain, so no domain transfer exists.
// - The block recalibrates its capture phase at a regular interval against the returned read clock.
// - DDR modes share bidirectional data and strobe pins; QDR II writes on a separate output group.
// - The data bus is configurable to 8, 9, 16, 18, 32 or 36 lines.
// - DDR and DDR2 memory always use eight-line strobe groups, combined for wider buses.
// - The 9, 18 and 36 line modes serve QDR II with one, two or four parity bits.
// - Only single-ended strobes exist; there is no complementary strobe output.
// - Writes are masked by data mask pins for DDR or byte write selects for QDR II.
module memory_phy_dq_grouping #(
  parameter int HALF_PER = phy_dq_pkg::HALF_PERIOD_CYC,
  parameter int RD_LAT = phy_dq_pkg::READ_LATENCY,
  parameter int CAL_INTERVAL = phy_dq_pkg::CAL_INTERVAL_CYC,
  parameter int CAP_RST = phy_dq_pkg::CAP_PHASE_RST
) (
  input logic clk_sys,
  input logic rst_n,
  input logic mem_type,
  input logic [2:0] bus_mode,
  input logic wr_valid,
  input logic [35:0] wr_data_rise,
  input logic [35:0] wr_data_fall,
  input logic [3:0] wr_mask_rise,
  input logic [3:0] wr_mask_fall,
  input logic rd_req,
  output logic req_ready,
  output logic rd_valid,
  output logic [35:0] rd_data_rise,
  output logic [35:0] rd_data_fall,
  output logic [3:0] rd_parity_err,
  output logic mode_err,
  output logic cal_busy,
  output logic [$clog2(2*HALF_PER)-1:0] cap_phase,
  output logic mem_ck,
  output logic mem_ck_n,
  input logic [35:0] dq_i,
  output logic [35:0] dq_o,
  output logic [35:0] dq_oe,
  output logic [35:0] d_o,
  output logic [3:0] dqs_o,
  output logic [3:0] dqs_oe,
  output logic [3:0] dm_o,
  output logic [3:0] bws_n_o,
  input logic cq_i
);

  localparam int PER = 2 * HALF_PER;
  localparam int PW = $clog2(PER);
  localparam int QTR = HALF_PER / 2;
  localparam int CW = $clog2(CAL_INTERVAL + 1);
  localparam int LANES = phy_dq_pkg::DQ_LANES;
  localparam int GRPS = phy_dq_pkg::STROBE_GROUPS;

  if (HALF_PER < 2 || RD_LAT < 2 || CAL_INTERVAL < 2 || CAP_RST < 0 || CAP_RST >= PER) begin
    $error("memory_phy_dq_grouping: parameter out of range");
  end

  // Mode decode.
  logic qdr_mode;
  logic nine_mode;
  logic eight_mode;
  logic mode_ok;
  logic [5:0] width;
  logic [2:0] ngroups;
  logic [LANES-1:0] lane_en;
  logic [GRPS-1:0] grp_en;

  assign qdr_mode = mem_type == phy_dq_pkg::MEM_QDR;
  assign nine_mode = bus_mode == phy_dq_pkg::BUS_X9 || bus_mode == phy_dq_pkg::BUS_X18 ||
                     bus_mode == phy_dq_pkg::BUS_X36;
  assign eight_mode = bus_mode == phy_dq_pkg::BUS_X8 || bus_mode == phy_dq_pkg::BUS_X16 ||
                      bus_mode == phy_dq_pkg::BUS_X32;
  assign mode_ok = qdr_mode ? nine_mode : eight_mode;
  assign ngroups = (bus_mode == phy_dq_pkg::BUS_X8 || bus_mode == phy_dq_pkg::BUS_X9) ? 3'h1 :
                   (bus_mode == phy_dq_pkg::BUS_X16 || bus_mode == phy_dq_pkg::BUS_X18) ? 3'h2 :
                   3'h4;
  assign width = nine_mode ? 6'(ngroups) * 6'(phy_dq_pkg::QDR_GROUP_BITS) :
                             6'(ngroups) * 6'(phy_dq_pkg::DDR_GROUP_BITS);

  // Phase divider: one memory clock period is PER system cycles.
  logic [PW-1:0] phase_q;
  logic [PW-1:0] phase_d;
  logic last_slot;
  logic first_slot;
  logic mid_slot;
  logic q1_slot;
  logic q3_slot;

  assign last_slot = phase_q == PW'(PER - 1);
  assign first_slot = phase_q == '0;
  assign mid_slot = phase_q == PW'(HALF_PER);
  assign q1_slot = phase_q == PW'(QTR);
  assign q3_slot = phase_q == PW'(HALF_PER + QTR);
  assign phase_d = last_slot ? '0 : phase_q + PW'(1);

  // Request slot and operation of the coming period.
  logic req_ready_q;
  logic wr_take;
  logic rd_take;
  phy_dq_pkg::op_type op_q;
  phy_dq_pkg::op_type op_d;
  logic wr_op;
  logic rd_op;

  assign wr_take = req_ready_q && wr_valid;
  assign rd_take = req_ready_q && !wr_valid && rd_req;
  assign op_d = wr_take ? phy_dq_pkg::OP_WRITE : rd_take ? phy_dq_pkg::OP_READ :
                phy_dq_pkg::OP_IDLE;
  assign wr_op = op_q == phy_dq_pkg::OP_WRITE;
  assign rd_op = op_q == phy_dq_pkg::OP_READ;

  // Write word latches and parity insertion.
  logic [35:0] wr_rise_q;
  logic [35:0] wr_fall_q;
  logic [3:0] mask_rise_q;
  logic [3:0] mask_fall_q;
  logic [35:0] out_rise;
  logic [35:0] out_fall;

  // Synchronised pins.
  logic [36:0] pin_s;
  logic [35:0] dq_s;
  logic cq_s;

  assign dq_s = pin_s[35:0];
  assign cq_s = pin_s[36];

  // Read capture.
  logic [35:0] cap_rise_q;
  logic [RD_LAT-1:0] rd_pend_q;
  logic [RD_LAT-1:0] rd_pend_d;
  logic cap_arm_q;
  logic fall_arm_q;
  logic arm_set;
  logic rise_hit;
  logic fall_hit;
  logic [PW-1:0] cap_phase_q;
  logic [PW-1:0] cap_fall;
  logic [PW:0] fall_sum;
  logic [35:0] rd_word;
  logic [3:0] par_chk;

  // Calibration.
  logic cal_due_q;
  logic [CW-1:0] cal_cnt_q;
  logic cq_prev_q;
  logic cq_rise;
  logic cal_hit;
  logic [PW:0] cal_sum;
  logic [PW-1:0] cal_phase;

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign lane_en[i] = 6'(i) < width;
    if (i % phy_dq_pkg::QDR_GROUP_BITS == phy_dq_pkg::QDR_GROUP_BITS - 1) begin : g_par
      assign out_rise[i] = qdr_mode ? ^wr_rise_q[i-8 +: 8] : wr_rise_q[i];
      assign out_fall[i] = qdr_mode ? ^wr_fall_q[i-8 +: 8] : wr_fall_q[i];
      assign par_chk[i / phy_dq_pkg::QDR_GROUP_BITS] = ^dq_s[i-8 +: 9];
    end else begin : g_dat
      assign out_rise[i] = wr_rise_q[i];
      assign out_fall[i] = wr_fall_q[i];
    end
  end

  for (genvar g = 0; g < GRPS; g++) begin : g_grp
    assign grp_en[g] = 3'(g) < ngroups;
  end

  assign rd_word = dq_s & lane_en;

  sync_2ff #(
    .WIDTH(37)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in({cq_i, dq_i}),
    .sync_q(pin_s)
  );

  // Capture phases come from the internal divider, never from the strobe pins.
  assign rd_pend_d = {rd_pend_q[RD_LAT-2:0], rd_op};
  assign arm_set = last_slot && rd_pend_d[RD_LAT-1];
  // A due calibration holds the capture so that the stale phase never samples a word.
  assign rise_hit = cap_arm_q && !cal_due_q && phase_q == cap_phase_q;
  assign fall_sum = {1'b0, cap_phase_q} + (PW + 1)'(HALF_PER);
  assign cap_fall = fall_sum >= (PW + 1)'(PER) ? PW'(fall_sum - (PW + 1)'(PER)) : PW'(fall_sum);
  assign fall_hit = fall_arm_q && phase_q == cap_fall;

  // Calibration centres the capture phase a quarter period after a read clock edge.
  assign cq_rise = cq_s && !cq_prev_q;
  assign cal_hit = cal_due_q && cap_arm_q && cq_rise;
  assign cal_sum = {1'b0, phase_q} + (PW + 1)'(QTR);
  assign cal_phase = cal_sum >= (PW + 1)'(PER) ? PW'(cal_sum - (PW + 1)'(PER)) : PW'(cal_sum);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= '0;
      req_ready_q <= 1'b0;
      op_q <= phy_dq_pkg::OP_IDLE;
    end else begin
      phase_q <= phase_d;
      req_ready_q <= phase_q == PW'(PER - 2) && mode_ok;
      if (last_slot) begin
        op_q <= op_d;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_rise_q <= '0;
      wr_fall_q <= '0;
      mask_rise_q <= '0;
      mask_fall_q <= '0;
    end else if (wr_take) begin
      wr_rise_q <= wr_data_rise;
      wr_fall_q <= wr_data_fall;
      mask_rise_q <= wr_mask_rise;
      mask_fall_q <= wr_mask_fall;
    end
  end

  // Memory clock and its complement.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_ck <= 1'b0;
      mem_ck_n <= 1'b1;
    end else if (first_slot || mid_slot) begin
      mem_ck <= first_slot;
      mem_ck_n <= !first_slot;
    end
  end

  // Write data: rise word in the first half, fall word in the second.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dq_o <= '0;
      dq_oe <= '0;
      d_o <= '0;
    end else if (first_slot || mid_slot) begin
      dq_o <= (wr_op && !qdr_mode) ? ((first_slot ? out_rise : out_fall) & lane_en) : '0;
      dq_oe <= (wr_op && !qdr_mode) ? lane_en : '0;
      d_o <= (wr_op && qdr_mode) ? ((first_slot ? out_rise : out_fall) & lane_en) : '0;
    end
  end

  // Single-ended strobe, centred in each data half, only while writing DDR.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dqs_o <= '0;
      dqs_oe <= '0;
    end else begin
      if (first_slot) begin
        dqs_oe <= (wr_op && !qdr_mode) ? grp_en : '0;
      end
      if (q1_slot || q3_slot) begin
        dqs_o <= (wr_op && !qdr_mode && q1_slot) ? grp_en : '0;
      end
    end
  end

  // Write masks follow the memory type.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dm_o <= '0;
      bws_n_o <= 4'hF;
    end else if (first_slot || mid_slot) begin
      dm_o <= (wr_op && !qdr_mode) ? ((first_slot ? mask_rise_q : mask_fall_q) & grp_en) : '0;
      bws_n_o <= (wr_op && qdr_mode) ? ((first_slot ? mask_rise_q : mask_fall_q) | ~grp_en) :
                 4'hF;
    end
  end

  // Read capture runs on the system clock only.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend_q <= '0;
      cap_arm_q <= 1'b0;
      fall_arm_q <= 1'b0;
      cap_rise_q <= '0;
    end else begin
      if (last_slot) begin
        rd_pend_q <= rd_pend_d;
      end
      cap_arm_q <= arm_set ? 1'b1 : rise_hit ? 1'b0 : cap_arm_q;
      fall_arm_q <= rise_hit ? 1'b1 : fall_hit ? 1'b0 : fall_arm_q;
      if (rise_hit) begin
        cap_rise_q <= rd_word;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data_rise <= '0;
      rd_data_fall <= '0;
      rd_parity_err <= '0;
    end else begin
      rd_valid <= fall_hit;
      if (fall_hit) begin
        rd_data_rise <= cap_rise_q;
        rd_data_fall <= rd_word;
        rd_parity_err <= (qdr_mode && nine_mode) ? (par_chk & grp_en) : '0;
      end
    end
  end

  // Periodic calibration timer and phase update.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cal_due_q <= 1'b1;
      cal_cnt_q <= '0;
      cq_prev_q <= 1'b0;
      cap_phase_q <= PW'(CAP_RST);
    end else begin
      cq_prev_q <= cq_s;
      if (cal_hit) begin
        cap_phase_q <= cal_phase;
        cal_due_q <= 1'b0;
        cal_cnt_q <= '0;
      end else if (!cal_due_q) begin
        if (cal_cnt_q == CW'(CAL_INTERVAL - 1)) begin
          cal_due_q <= 1'b1;
          cal_cnt_q <= '0;
        end else begin
          cal_cnt_q <= cal_cnt_q + CW'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_err <= 1'b0;
      req_ready <= 1'b0;
      cal_busy <= 1'b1;
      cap_phase <= PW'(CAP_RST);
    end else begin
      mode_err <= !mode_ok;
      req_ready <= phase_q == PW'(PER - 2) && mode_ok;
      cal_busy <= cal_hit ? 1'b0 : cal_due_q;
      cap_phase <= cal_hit ? cal_phase : cap_phase_q;
    end
  end

endmodule

// >>> src/sync_2ff.sv
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input logic clk_sys,
  input logic rst_n,
  input logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_q
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

endmodule

// >>> verif/mem_partner_model.sv
module mem_partner_model (
  input logic clk_sys,
  input logic mem_type,
  input logic mem_ck,
  input logic [35:0] dq_o,
  input logic [35:0] dq_oe,
  input logic [35:0] d_o,
  input logic [3:0] dm_o,
  input logic [3:0] bws_n_o,
  input logic flip_par,
  input int lag,
  output logic [35:0] dq_in,
  output logic cq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [35:0] rise_q = 36'h0;
  logic [35:0] fall_q = 36'h0;
  logic [35:0] out_q;
  int g;
  initial begin
    cq = 1'b0;
    out_q = 36'h0;
  end
  // Lanes are stored mid-cycle, where the write word has settled.
  always @(negedge clk_sys) begin
    for (int i = 0; i < 36; i++) begin
      g = mem_type ? i / 9 : i / 8;
      if (mem_type ? !bws_n_o[g] : (dq_oe[i] && !dm_o[g])) begin
        if (mem_ck)
          rise_q[i] <= mem_type ? d_o[i] : dq_o[i];
        else
          fall_q[i] <= mem_type ? d_o[i] : dq_o[i];
      end
    end
  end
  always @(mem_ck or rise_q or fall_q or flip_par)
    out_q <= #(lag) (mem_ck ? rise_q : fall_q) ^ {35'h0, flip_par};
  always @(mem_ck)
    cq <= #(lag) mem_ck;
  assign dq_in = (dq_oe & dq_o) | (~dq_oe & out_q);
endmodule

// >>> verif/memory_phy_dq_grouping_assertions.sv
module memory_phy_dq_grouping_checker #(
  parameter int HALF_PER = 4
) (
  input logic clk_sys,
  input logic rst_n,
  input logic mem_type,
  input logic [2:0] bus_mode,
  input logic wr_valid,
  input logic [35:0] wr_data_rise,
  input logic [3:0] wr_mask_rise,
  input logic rd_req,
  input logic req_ready,
  input logic rd_valid,
  input logic mode_err,
  input logic cal_busy,
  input logic [$clog2(2*HALF_PER)-1:0] cap_phase,
  input logic mem_ck,
  input logic mem_ck_n,
  input logic [35:0] dq_o,
  input logic [35:0] dq_oe,
  input logic [35:0] d_o,
  input logic [3:0] dqs_oe,
  input logic [3:0] bws_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  AST_CK_PAIR: assert property (mem_ck_n == !mem_ck)
    else $error("memory clock pair not complementary");
  AST_RDY_SPACING: assert property (req_ready |=> !req_ready [*7])
    else $error("request slots closer than one memory period");
  AST_MODE_REFUSE: assert property (mode_err |-> !req_ready)
    else $error("request slot offered in an illegal mode");
  AST_QDR_NO_SHARED: assert property (mem_type |-> dq_oe == 36'h0 && dqs_oe == 4'h0)
    else $error("shared pins driven in separate-bus mode");
  AST_STROBE_WRITE: assert property ($rose(dqs_oe[0]) |-> $past(req_ready && wr_valid, 2))
    else $error("strobe driven without a write");
  AST_READ_RELEASE: assert property (req_ready && rd_req && !wr_valid |=>
    ##1 (dq_oe == 36'h0 && dqs_oe == 4'h0) [*8])
    else $error("pins driven during a read period");
  AST_READ_LATENCY: assert property (req_ready && rd_req && !wr_valid |-> ##[22:37] rd_valid)
    else $error("read data not delivered in time");
  AST_DDR_X8_LANES: assert property (!mem_type && bus_mode == 3'h0 && req_ready && wr_valid |=>
    ##1 dq_oe == 36'h0_0000_00FF && dqs_oe == 4'h1 &&
    dq_o == ($past(wr_data_rise, 2) & 36'h0_0000_00FF))
    else $error("eight-lane write drives wrong lanes");
  AST_QDR_PARITY: assert property (mem_type && bus_mode == 3'h1 && req_ready && wr_valid |=>
    ##1 d_o[8] == ^$past(wr_data_rise[7:0], 2) && bws_n_o[0] == $past(wr_mask_rise[0], 2))
    else $error("parity lane or byte select wrong");
  AST_CAL_PHASE: assert property ($changed(cap_phase) |-> $past(cal_busy))
    else $error("capture phase moved outside calibration");
endmodule

// >>> verif/memory_phy_dq_grouping_tb.sv
module memory_phy_dq_grouping_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic mem_type = 1'b0;
  logic [2:0] bus_mode = 3'h0;
  logic wr_valid = 1'b0;
  logic rd_req = 1'b0;
  logic flip_par = 1'b0;
  logic [35:0] wr_data_rise = 36'h0;
  logic [35:0] wr_data_fall = 36'h0;
  logic [3:0] wr_mask_rise = 4'h0;
  logic [3:0] wr_mask_fall = 4'h0;
  int lag = 20;
  int miscompares = 0;
  int checked = 0;
  logic req_ready, rd_valid, mode_err, cal_busy, mem_ck, mem_ck_n, cq_i, bad;
  logic [35:0] rd_data_rise, rd_data_fall, dq_i, dq_o, dq_oe, d_o;
  logic [3:0] rd_parity_err, dqs_o, dqs_oe, dm_o, bws_n_o;
  logic [2:0] cap_phase;

  always #50 clk_sys = ~clk_sys;

  memory_phy_dq_grouping #(.CAL_INTERVAL(50)) dut (
    .clk_sys, .rst_n, .mem_type, .bus_mode, .wr_valid, .wr_data_rise, .wr_data_fall,
    .wr_mask_rise, .wr_mask_fall, .rd_req, .req_ready, .rd_valid, .rd_data_rise,
    .rd_data_fall, .rd_parity_err, .mode_err, .cal_busy, .cap_phase, .mem_ck, .mem_ck_n,
    .dq_i, .dq_o, .dq_oe, .d_o, .dqs_o, .dqs_oe, .dm_o, .bws_n_o, .cq_i);

  mem_partner_model u_mem (.clk_sys, .mem_type, .mem_ck, .dq_o, .dq_oe, .d_o, .dm_o,
    .bws_n_o, .flip_par, .lag, .dq_in(dq_i), .cq(cq_i));

  task chk(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task final_report;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task op(input logic w, input logic [35:0] r, input logic [35:0] f, input logic [3:0] mr,
          input logic [3:0] mf);
    @(negedge clk_sys);
    wr_valid = w;
    rd_req = !w;
    wr_data_rise = r;
    wr_data_fall = f;
    wr_mask_rise = mr;
    wr_mask_fall = mf;
    for (int n = 0; n < 20 && req_ready !== 1'b1; n++)
      @(negedge clk_sys);
    // The slot is taken at the rising edge before this falling edge; pins follow a cycle later.
    @(negedge clk_sys);
    wr_valid = 1'b0;
    rd_req = 1'b0;
    @(negedge clk_sys);
  endtask

  task wait_rd;
    for (int n = 0; n < 40 && rd_valid !== 1'b1; n++)
      @(negedge clk_sys);
    chk(rd_valid, 1'b1);
  endtask

  task rd(input logic [35:0] er, input logic [35:0] ef, input logic [3:0] ep);
    op(1'b0, 36'h0, 36'h0, 4'h0, 4'h0);
    wait_rd();
    chk(rd_data_rise, er);
    chk(rd_data_fall, ef);
    chk(rd_parity_err, ep);
  endtask

  task t_reset;
    chk({mem_ck_n, bws_n_o, cal_busy, req_ready}, 7'h7E);
    chk(cap_phase, 3'h2);
  endtask

  // A first read after reset or a timing change lets the capture phase settle.
  task t_cal(input logic [2:0] ep);
    for (int n = 0; n < 80 && cal_busy !== 1'b1; n++)
      @(negedge clk_sys);
    op(1'b0, 36'h0, 36'h0, 4'h0, 4'h0);
    wait_rd();
    chk(cal_busy, 1'b0);
    chk(cap_phase, ep);
  endtask

  task t_modes;
    for (int m = 0; m < 16; m++) begin
      @(negedge clk_sys);
      mem_type = m[0];
      bus_mode = 3'(m / 2);
      bad = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk(mode_err, 1'(m[0] != bus_mode[0] || bus_mode > 3'h5));
      repeat (9) @(negedge clk_sys) bad |= mode_err & req_ready;
      chk(bad, 1'b0);
    end
  endtask

  task t_ddr8;
    mem_type = 1'b0;
    bus_mode = 3'h0;
    op(1'b1, 36'hA_5A5A_5AC3, 36'h5_A5A5_A53C, 4'h0, 4'h1);
    chk({dq_oe, dq_o}, {36'hFF, 36'hC3});
    chk(dm_o, 4'h0);
    repeat (2) @(negedge clk_sys);
    chk(dqs_o, 4'h1);
    repeat (2) @(negedge clk_sys);
    chk(dq_o, 36'h3C);
    chk(dm_o, 4'h1);
    repeat (2) @(negedge clk_sys);
    chk(dqs_o, 4'h0);
    rd(36'hC3, 36'h0, 4'h0);
  endtask

  task t_ddr32;
    bus_mode = 3'h4;
    lag = 130;
    t_cal(3'h6);
    op(1'b1, 36'hF_1234_5678, 36'h0_9ABC_DEF0, 4'h4, 4'h0);
    chk(dqs_oe, 4'hF);
    chk(dq_oe, 36'hF_FFFF_FFFF & 36'h0_FFFF_FFFF);
    rd(36'h0_1200_5678, 36'h0_9ABC_DEF0, 4'h0);
  endtask

  task t_qdr;
    mem_type = 1'b1;
    bus_mode = 3'h1;
    op(1'b1, 36'h103, 36'h001, 4'h0, 4'h0);
    chk(d_o, 36'h003);
    chk(bws_n_o[0], 1'b0);
    chk(dq_oe, 36'h0);
    repeat (4) @(negedge clk_sys);
    chk(d_o, 36'h101);
    rd(36'h003, 36'h101, 4'h0);
    flip_par = 1'b1;
    rd(36'h002, 36'h100, 4'h1);
    flip_par = 1'b0;
  endtask

  initial begin
    repeat (8) @(negedge clk_sys);
    t_reset();
    rst_n = 1'b1;
    t_cal(3'h5);
    t_ddr8();
    t_ddr32();
    t_qdr();
    t_modes();
    final_report();
  end

  initial begin
    #400000;
    miscompares++;
    final_report();
  end
endmodule

bind memory_phy_dq_grouping memory_phy_dq_grouping_checker #(.HALF_PER(HALF_PER)) u_chk (
  .clk_sys, .rst_n, .mem_type, .bus_mode, .wr_valid, .wr_data_rise, .wr_mask_rise, .rd_req,
  .req_ready, .rd_valid, .mode_err, .cal_busy, .cap_phase, .mem_ck, .mem_ck_n, .dq_o, .dq_oe,
  .d_o, .dqs_oe, .bws_n_o);
